// ---- hw/dma_channel_control_status.sv ----
// Register file, flags and count logic of a multi-channel DMA controller.
// ==========================================================================
// What this block does
// - Registers accept byte, halfword and word writes.
// - Channels six and seven inert in five-channel build.
// - Status bits 27..3 step four hold error flags.
// - Status bits 26..2 hold half-transfer flags.
// - Status bits 25..1 hold transfer-complete flags.
// - Status bits 24..0 hold any-event flags.
// - Status and clear bits 31:28 read zero.
// - Writing one clears matching flag; zero does nothing.
// - Global clear bit clears all four channel flags.
// - Config register at 0x08 plus 20 per channel.
// - Count register at 0x0C plus 20 per channel.
// - Config bit 14 selects memory-to-memory mode.
// - Config bits 13:12 hold channel priority.
// - Config bits 11:10 hold memory data width.
// - Config bits 9:8 hold peripheral data width.
// - Config bit 7 enables memory address increment.
// - Config bit 6 enables peripheral address increment.
// - Config bit 5 enables circular restart.
// - Config bit 4 selects transfer direction.
// - Config bits 3:1 interrupt enables, bit 0 enable.
// - Count writable only while channel disabled.
// - Count decrements after each completed transfer.
// - Count stays zero, or reloads in circular mode.
// - Zero count means no transfer is served.
// - Bus error clears enable and sets error flag.
// - Interrupt when flag and its enable both set.
// - Wide peripheral widths ignore low address bits.
module dma_channel_control_status
  import dma_ctl_pkg::*;
#(
  parameter int CHANNELS = BUILT_CH
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic [NUM_CH-1:0] i_xfer_req,
  input wire logic i_xfer_done,
  input wire logic i_xfer_error,
  input wire logic [31:0] i_periph_addr,
  output logic o_grant_valid,
  output logic [2:0] o_grant_ch,
  output logic o_grant_dir,
  output logic o_grant_copy,
  output logic o_grant_mstep,
  output logic o_grant_pstep,
  output logic [1:0] o_grant_memory_word_width,
  output logic [1:0] o_grant_peripheral_word_width,
  output logic [31:0] o_periph_addr_aligned,
  output logic [NUM_CH-1:0] o_irq
);

  // ========================================================================
  // Storage and decode
  logic [3:0] flags_reg [NUM_CH];
  logic [CFG_WIDTH-1:0] cfg_reg [NUM_CH];
  logic [CNT_WIDTH-1:0] cnt_reg [NUM_CH];
  logic [CNT_WIDTH-1:0] reload_reg [NUM_CH];
  logic half_seen_reg [NUM_CH];
  logic [2:0] grant_ch_reg;
  logic grant_valid_reg;
  logic [NUM_CH-1:0] sel_cfg;
  logic [NUM_CH-1:0] sel_cnt;
  logic wr_access;
  logic [31:0] wmask;
  logic [31:0] wdata_m;
  logic [27:0] clr_bits;
  logic [31:0] rdata_next;
  logic [NUM_CH-1:0] live;

  // Zero wait states: every access completes in its first access cycle.
  assign o_pready = 1'b1;
  assign o_pslverr = 1'b0;
  assign wr_access = i_psel && i_penable && i_pwrite;

  // Byte strobes turn halfword and byte writes into masked word writes.
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wmask[b*8 +: 8] = {8{i_pstrb[b]}};
    end
    wdata_m = i_pwdata & wmask;
  end

  assign clr_bits = (wr_access && i_paddr == ADDR_CLEAR) ?
                    wdata_m[27:0] : 28'h0000000;

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      localparam logic [11:0] CH_OFS = CH_STRIDE * 12'(g);
      logic is_done;
      logic is_err;
      logic clr_all;
      logic [3:0] set_v;
      logic [3:0] clr_v;
      logic [CNT_WIDTH-1:0] cnt_dec;

      assign live[g] = (g < CHANNELS);
      assign sel_cfg[g] = live[g] && i_paddr == ADDR_CFG_BASE + CH_OFS;
      assign sel_cnt[g] = live[g] && i_paddr == ADDR_CNT_BASE + CH_OFS;
      assign is_done = grant_valid_reg && grant_ch_reg == 3'(g) &&
                       i_xfer_done && !i_xfer_error;
      assign is_err = grant_valid_reg && grant_ch_reg == 3'(g) &&
                      i_xfer_error;
      assign cnt_dec = cnt_reg[g] - 16'h0001;
      assign clr_all = clr_bits[g*4 + FLAG_ANY];

      // Hardware events; the set wins over a clear in the same cycle.
      always_comb begin
        set_v = 4'h0;
        set_v[FLAG_ERR] = is_err;
        set_v[FLAG_DONE] = is_done && cnt_reg[g] == 16'h0001;
        set_v[FLAG_HALF] = is_done && !half_seen_reg[g] &&
                           cnt_dec <= (reload_reg[g] >> 1);
        set_v[FLAG_ANY] = is_err || set_v[FLAG_DONE] ||
                          set_v[FLAG_HALF];
        clr_v = clr_bits[g*4 +: 4] | {4{clr_all}};
      end

      always_ff @(posedge i_clk) begin
        if (i_rst || !live[g]) begin
          flags_reg[g] <= 4'h0;
        end else begin
          flags_reg[g] <= (flags_reg[g] & ~clr_v) | set_v;
        end
      end

      always_ff @(posedge i_clk) begin
        if (i_rst || !live[g]) begin
          cfg_reg[g] <= RESET_VALUE[CFG_WIDTH-1:0];
        end else begin
          if (wr_access && sel_cfg[g]) begin
            cfg_reg[g] <= (cfg_reg[g] & ~wmask[CFG_WIDTH-1:0]) |
                          wdata_m[CFG_WIDTH-1:0];
          end
          if (is_err) begin
            cfg_reg[g][CFG_EN] <= 1'b0;
          end
        end
      end

      always_ff @(posedge i_clk) begin
        if (i_rst || !live[g]) begin
          cnt_reg[g] <= RESET_VALUE[CNT_WIDTH-1:0];
          reload_reg[g] <= RESET_VALUE[CNT_WIDTH-1:0];
          half_seen_reg[g] <= 1'b0;
        end else if (wr_access && sel_cnt[g] && !cfg_reg[g][CFG_EN]) begin
          cnt_reg[g] <= (cnt_reg[g] & ~wmask[15:0]) | wdata_m[15:0];
          reload_reg[g] <= (cnt_reg[g] & ~wmask[15:0]) | wdata_m[15:0];
          half_seen_reg[g] <= 1'b0;
        end else if (is_done && cnt_reg[g] != 16'h0000) begin
          if (cnt_reg[g] == 16'h0001 && cfg_reg[g][CFG_WRAP]) begin
            cnt_reg[g] <= reload_reg[g];
            half_seen_reg[g] <= 1'b0;
          end else begin
            cnt_reg[g] <= cnt_dec;
            if (set_v[FLAG_HALF]) begin
              half_seen_reg[g] <= 1'b1;
            end
          end
        end
      end

      // Interrupt line per channel, gated by its three enables.
      assign o_irq[g] = live[g] &&
        ((flags_reg[g][FLAG_ERR] && cfg_reg[g][CFG_ERR_IE]) ||
         (flags_reg[g][FLAG_HALF] && cfg_reg[g][CFG_HALF_IE]) ||
         (flags_reg[g][FLAG_DONE] && cfg_reg[g][CFG_DONE_IE]));
    end
  endgenerate

  // ========================================================================
  // Read path
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (i_paddr == ADDR_STATUS) begin
      for (int c = 0; c < NUM_CH; c++) begin
        rdata_next[c*4 +: 4] = flags_reg[c];
      end
    end
    for (int c = 0; c < NUM_CH; c++) begin
      if (sel_cfg[c]) begin
        rdata_next[CFG_WIDTH-1:0] = cfg_reg[c];
      end
      if (sel_cnt[c]) begin
        rdata_next[CNT_WIDTH-1:0] = cnt_reg[c];
      end
    end
  end

  // Read data is registered during the setup cycle so it is stable in
  // the access cycle, keeping the bus answer at zero wait states.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_prdata <= 32'h0000_0000;
    end else if (i_psel && !i_penable && !i_pwrite) begin
      o_prdata <= rdata_next;
    end
  end

  // ========================================================================
  // Arbitration
  logic pick_valid;
  logic [2:0] pick_ch;
  logic [1:0] pick_prio;

  // Strict comparison keeps the first (lowest) channel on a tie.
  // The channel being answered this cycle is skipped: its count and
  // enable change at this very edge, so picking it again would serve a
  // count that has just reached zero or a channel that an error disabled.
  always_comb begin
    pick_valid = 1'b0;
    pick_ch = 3'h0;
    pick_prio = 2'h0;
    for (int c = 0; c < NUM_CH; c++) begin
      if (live[c] && i_xfer_req[c] && cfg_reg[c][CFG_EN] &&
          cnt_reg[c] != 16'h0000 &&
          !(grant_valid_reg && grant_ch_reg == 3'(c) &&
            (i_xfer_done || i_xfer_error))) begin
        if (!pick_valid ||
            cfg_reg[c][CFG_PRIO_LO +: 2] > pick_prio) begin
          pick_valid = 1'b1;
          pick_ch = 3'(c);
          pick_prio = cfg_reg[c][CFG_PRIO_LO +: 2];
        end
      end
    end
  end

  // A grant holds until the mover reports done or error for it.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      grant_valid_reg <= 1'b0;
      grant_ch_reg <= 3'h0;
    end else if (!grant_valid_reg || i_xfer_done || i_xfer_error) begin
      grant_valid_reg <= pick_valid;
      grant_ch_reg <= pick_ch;
    end
  end

  assign o_grant_valid = grant_valid_reg;
  assign o_grant_ch = grant_ch_reg;
  assign o_grant_dir = cfg_reg[grant_ch_reg][CFG_DIR];
  assign o_grant_copy = cfg_reg[grant_ch_reg][CFG_COPY];
  assign o_grant_mstep = cfg_reg[grant_ch_reg][CFG_MSTEP];
  assign o_grant_pstep = cfg_reg[grant_ch_reg][CFG_PSTEP];
  assign o_grant_memory_word_width = cfg_reg[grant_ch_reg][CFG_MEMORY_WORD_WIDTH_LO +: 2];
  assign o_grant_peripheral_word_width = cfg_reg[grant_ch_reg][CFG_PERIPHERAL_WORD_WIDTH_LO +: 2];

  // Wider peripheral accesses drop the low address bits.
  always_comb begin
    o_periph_addr_aligned = i_periph_addr;
    if (o_grant_peripheral_word_width == 2'h1) begin
      o_periph_addr_aligned[0] = 1'b0;
    end else if (o_grant_peripheral_word_width == 2'h2) begin
      o_periph_addr_aligned[1:0] = 2'h0;
    end
  end

  // ========================================================================
  // Checks
  // Per-channel checks watch channel index 0, except AST_DEAD_CH on index 6 and COV_HALF on
  // index 1; the logic is one generate body, so the other built channels share the same structure.
  AST_ERR_DISABLES: assert property (
    @(posedge i_clk) disable iff (i_rst)
    grant_valid_reg && i_xfer_error
    |=> !cfg_reg[$past(grant_ch_reg)][CFG_EN]
    && flags_reg[$past(grant_ch_reg)][FLAG_ERR])
    else $error("bus error did not disable channel");
  AST_ZERO_NO_GRANT: assert property (
    @(posedge i_clk) disable iff (i_rst)
    pick_valid |-> cnt_reg[pick_ch] != 16'h0000)
    else $error("zero count channel picked");
  AST_NO_STALE_PICK: assert property (
    @(posedge i_clk) disable iff (i_rst)
    pick_valid && grant_valid_reg && (i_xfer_done || i_xfer_error)
    |-> pick_ch != grant_ch_reg)
    else $error("answered channel picked again");
  AST_RESERVED_ZERO: assert property (
    @(posedge i_clk) disable iff (i_rst)
    i_psel && !i_penable && !i_pwrite |=> o_prdata[31:28] == 4'h0)
    else $error("reserved bits nonzero");
  AST_CLEAR_ALL: assert property (
    @(posedge i_clk) disable iff (i_rst)
    clr_bits[0] && !(grant_valid_reg && grant_ch_reg == 3'h0 &&
    (i_xfer_done || i_xfer_error)) |=> flags_reg[0] == 4'h0)
    else $error("global clear left flags");
  AST_ANY_FOLLOWS: assert property (
    @(posedge i_clk) disable iff (i_rst)
    $rose(flags_reg[0][FLAG_DONE]) |-> flags_reg[0][FLAG_ANY])
    else $error("any flag missing");
  AST_DONE_SETS: assert property (
    @(posedge i_clk) disable iff (i_rst)
    grant_valid_reg && grant_ch_reg == 3'h0 && i_xfer_done &&
    !i_xfer_error && cnt_reg[0] == 16'h0001
    |=> flags_reg[0][FLAG_DONE])
    else $error("done flag not set at last transfer");
  AST_WRAP_RELOAD: assert property (
    @(posedge i_clk) disable iff (i_rst)
    grant_valid_reg && grant_ch_reg == 3'h0 && i_xfer_done &&
    !i_xfer_error && cnt_reg[0] == 16'h0001 && cfg_reg[0][CFG_WRAP]
    |=> cnt_reg[0] == $past(reload_reg[0]))
    else $error("circular count not reloaded");
  AST_CNT_LOCKED: assert property (
    @(posedge i_clk) disable iff (i_rst)
    cfg_reg[0][CFG_EN] && !(grant_valid_reg && grant_ch_reg == 3'h0)
    |=> cnt_reg[0] == $past(cnt_reg[0]))
    else $error("count changed while enabled");
  AST_DEC_ONE: assert property (
    @(posedge i_clk) disable iff (i_rst)
    grant_valid_reg && grant_ch_reg == 3'h0 && i_xfer_done &&
    !i_xfer_error && cnt_reg[0] > 16'h0001
    |=> cnt_reg[0] == $past(cnt_reg[0]) - 16'h0001)
    else $error("count did not step by one");
  AST_DEAD_CH: assert property (
    @(posedge i_clk) disable iff (i_rst)
    ##1 flags_reg[6] == 4'h0 && cfg_reg[6] == 15'h0000)
    else $error("unbuilt channel active");
  AST_IRQ: assert property (
    @(posedge i_clk) disable iff (i_rst)
    flags_reg[0][FLAG_DONE] && cfg_reg[0][CFG_DONE_IE] |-> o_irq[0])
    else $error("irq missing");
  AST_ALIGN: assert property (
    @(posedge i_clk) disable iff (i_rst)
    o_grant_peripheral_word_width == 2'h2 |-> o_periph_addr_aligned[1:0] == 2'h0)
    else $error("word access not aligned");
  COV_DONE: cover property (@(posedge i_clk) $rose(flags_reg[0][FLAG_DONE]));
  COV_HALF: cover property (@(posedge i_clk) $rose(flags_reg[1][FLAG_HALF]));
  COV_ERR: cover property (@(posedge i_clk) $rose(flags_reg[0][FLAG_ERR]));
  COV_WRAP: cover property (@(posedge i_clk)
    cfg_reg[0][CFG_WRAP] && $rose(flags_reg[0][FLAG_DONE]));

endmodule : dma_channel_control_status

// ---- hw/dma_ctl_pkg.sv ----
// Constants, register map and field layout of the DMA channel control block.
package dma_ctl_pkg;
  localparam int NUM_CH = 7;
  localparam int BUILT_CH = 5;
  localparam logic [11:0] ADDR_STATUS = 12'h000;
  localparam logic [11:0] ADDR_CLEAR = 12'h004;
  localparam logic [11:0] ADDR_CFG_BASE = 12'h008;
  localparam logic [11:0] ADDR_CNT_BASE = 12'h00c;
  localparam logic [11:0] CH_STRIDE = 12'h014;
  localparam logic [31:0] RESET_VALUE = 32'h0000_0000;
  localparam int FLAG_ANY = 0;
  localparam int FLAG_DONE = 1;
  localparam int FLAG_HALF = 2;
  localparam int FLAG_ERR = 3;
  localparam int CFG_WIDTH = 15;
  localparam int CFG_EN = 0;
  localparam int CFG_DONE_IE = 1;
  localparam int CFG_HALF_IE = 2;
  localparam int CFG_ERR_IE = 3;
  localparam int CFG_DIR = 4;
  localparam int CFG_WRAP = 5;
  localparam int CFG_PSTEP = 6;
  localparam int CFG_MSTEP = 7;
  localparam int CFG_PERIPHERAL_WORD_WIDTH_LO = 8;
  localparam int CFG_MEMORY_WORD_WIDTH_LO = 10;
  localparam int CFG_PRIO_LO = 12;
  localparam int CFG_COPY = 14;
  localparam int CNT_WIDTH = 16;
endpackage : dma_ctl_pkg

// ---- verification/dma_channel_control_status_test.sv ----
// Self-checking bench for the DMA channel control block.
module dma_channel_control_status_test import dma_ctl_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 1'b0, i_rst = 1'b1, i_psel = 1'b0, i_penable = 1'b0;
  logic i_pwrite = 1'b0, i_xfer_done, i_xfer_error;
  logic [11:0] i_paddr = 12'h000;
  logic [31:0] i_pwdata = 32'h0, i_periph_addr = 32'h0, o_prdata;
  logic [31:0] o_periph_addr_aligned, rd;
  logic [3:0] i_pstrb = 4'h0;
  logic [NUM_CH-1:0] i_xfer_req = '0, o_irq;
  logic o_pready, o_pslverr, o_grant_valid, o_grant_dir, o_grant_copy;
  logic o_grant_mstep, o_grant_pstep, slow = 1'b0, fail = 1'b0;
  logic [1:0] o_grant_memory_word_width, o_grant_peripheral_word_width;
  logic [2:0] o_grant_ch;
  int err_total = 0, checks = 0;

  dma_channel_control_status #(.CHANNELS(5)) i_dut (.*);
  xfer_partner i_far (.i_clk(i_clk), .i_rst(i_rst),
    .i_grant_valid(o_grant_valid), .i_slow(slow), .i_fail(fail),
    .o_done(i_xfer_done), .o_error(i_xfer_error));

  always #2.5 i_clk = ~i_clk;

  // =====
  // Bus tasks
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    i_pstrb <= s;
    @(posedge i_clk);
    i_penable <= 1'b1;
    do @(posedge i_clk); while (o_pready !== 1'b1);
    rd = o_prdata;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask : apb

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hf);
  endtask : wr

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, 4'h0);
    check(rd, e);
  endtask : rd_chk

  task automatic wait_flag(input int b);
    rd = 32'h0;
    for (int n = 0; n < 100 && rd[b] !== 1'b1; n++) begin
      apb(1'b0, ADDR_STATUS, 32'h0, 4'h0);
    end
  endtask : wait_flag

  function automatic logic [11:0] cfg_a(input int ch);
    return ADDR_CFG_BASE + CH_STRIDE * 12'(ch - 1);
  endfunction : cfg_a

  function automatic logic [11:0] cnt_a(input int ch);
    return ADDR_CNT_BASE + CH_STRIDE * 12'(ch - 1);
  endfunction : cnt_a

  task automatic tally_and_finish();
    if (err_total == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // =====
  // Tests
  initial begin
    repeat (4) @(posedge i_clk);
    i_rst <= 1'b0;
    rd_chk(cfg_a(1), 32'h0);
    rd_chk(cnt_a(1), 32'h0);
    rd_chk(12'h100, 32'h0);
    wr(ADDR_STATUS, 32'hffff_ffff);
    rd_chk(ADDR_STATUS, 32'h0);
    wr(cfg_a(2), 32'hffff_fffe);
    rd_chk(cfg_a(2), 32'h0000_7ffe);
    apb(1'b1, cfg_a(2), 32'h0, 4'h2);
    rd_chk(cfg_a(2), 32'h0000_00fe);
    wr(cfg_a(2), 32'h0);
    wr(cfg_a(6), 32'h0000_7ffe);
    rd_chk(cfg_a(6), 32'h0);
    // Plain run of four transfers with 32-bit peripheral width.
    wr(cnt_a(1), 32'h4);
    rd_chk(cnt_a(1), 32'h4);
    i_periph_addr <= 32'h0000_1237;
    wr(cfg_a(1), 32'h0000_06c3);
    i_xfer_req[0] <= 1'b1;
    for (int n = 0; n < 50 && o_grant_valid !== 1'b1; n++) @(posedge i_clk);
    check(o_periph_addr_aligned, 32'h0000_1234);
    check({23'h0, o_grant_ch, o_grant_dir, o_grant_copy, o_grant_mstep,
           o_grant_pstep, o_grant_memory_word_width}, 32'h0000_000d);
    check({30'h0, o_grant_peripheral_word_width}, 32'h2);
    wait_flag(FLAG_DONE);
    rd_chk(ADDR_STATUS, 32'h7);
    rd_chk(cnt_a(1), 32'h0);
    check({25'h0, o_irq}, 32'h1);
    wr(cnt_a(1), 32'h9);
    rd_chk(cnt_a(1), 32'h0);
    check({31'h0, o_grant_valid}, 32'h0);
    wr(ADDR_CLEAR, 32'h0);
    rd_chk(ADDR_STATUS, 32'h7);
    wr(ADDR_CLEAR, 32'h2);
    rd_chk(ADDR_STATUS, 32'h5);
    check({25'h0, o_irq}, 32'h0);
    wr(ADDR_CLEAR, 32'h1);
    rd_chk(ADDR_STATUS, 32'h0);
    // A count of one reloads to one, so any later read must show one.
    i_xfer_req[0] <= 1'b0;
    wr(cfg_a(1), 32'h0);
    wr(cnt_a(1), 32'h1);
    slow <= 1'b1;
    wr(cfg_a(1), 32'h0000_0021);
    i_xfer_req[0] <= 1'b1;
    wait_flag(FLAG_DONE);
    rd_chk(cnt_a(1), 32'h1);
    i_xfer_req[0] <= 1'b0;
    wr(cfg_a(1), 32'h0);
    repeat (20) @(posedge i_clk);
    wr(ADDR_CLEAR, 32'h1);
    // Bus error on channel three.
    slow <= 1'b0;
    fail <= 1'b1;
    wr(cnt_a(3), 32'h3);
    wr(cfg_a(3), 32'h0000_0009);
    i_xfer_req[2] <= 1'b1;
    wait_flag(11);
    rd_chk(cfg_a(3), 32'h8);
    wr(ADDR_CLEAR, 32'hf000_0000);
    rd_chk(ADDR_STATUS, 32'h0000_0900);
    check({25'h0, o_irq}, 32'h4);
    tally_and_finish();
  end

  initial begin
    repeat (20000) @(posedge i_clk);
    err_total++;
    tally_and_finish();
  end
endmodule : dma_channel_control_status_test

// ---- verification/xfer_partner.sv ----
// Far-side bus model that answers each granted transfer.
module xfer_partner (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_grant_valid,
  input wire logic i_slow,
  input wire logic i_fail,
  output logic o_done = 1'b0,
  output logic o_error = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  logic busy = 1'b0;
  logic gap = 1'b0;
  logic [1:0] wait_cnt = 2'h0;
  // =====
  // Answer engine
  // One idle edge follows each answer so the grant can move on first;
  // otherwise the stale grant would be answered twice.
  always @(posedge i_clk) begin
    o_done <= 1'b0;
    o_error <= 1'b0;
    gap <= 1'b0;
    if (i_rst) begin
      busy <= 1'b0;
    end else if (busy) begin
      if (wait_cnt == 2'h0) begin
        busy <= 1'b0;
        gap <= 1'b1;
        o_done <= !i_fail;
        o_error <= i_fail;
      end else begin
        wait_cnt <= wait_cnt - 2'h1;
      end
    end else if (i_grant_valid && !gap) begin
      busy <= 1'b1;
      wait_cnt <= i_slow ? 2'h3 : 2'h0;
    end
  end
endmodule : xfer_partner
